// [rtl/ipcr_pkg.sv]
package ipcr_pkg;
   // Register indices on the plain port
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CORE = 4'h1;
   localparam logic [3:0] ADDR_GCTL_A = 4'h2;
   localparam logic [3:0] ADDR_GCTL_B = 4'h3;
   localparam logic [3:0] ADDR_FLAG0 = 4'h4;
   localparam logic [3:0] ADDR_ENABLE0 = 4'h5;
   localparam logic [3:0] ADDR_PRIO0 = 4'h6;
   localparam logic [3:0] ADDR_PRIO1 = 4'h7;
   localparam logic [3:0] ADDR_PRIO2 = 4'h8;
   localparam logic [3:0] ADDR_PRIO3 = 4'h9;
   // Field positions
   localparam int PRIO_LOW_LSB = 5;
   localparam int PRIO_TOP_BIT = 3;
   localparam int NEST_DIS_BIT = 15;
   localparam int TRAP_EN_LSB = 8;
   localparam int TRAP_FLAG_LSB = 1;
   localparam int ALT_VEC_BIT = 15;
   localparam int TIMED_BLK_BIT = 14;
   localparam int EDGE_POL_LSB = 0;
   localparam int PRIO_FIELD_W = 4;
   // Reset values, and the level loaded on entry with nesting disabled
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [2:0] PRIO_MASK_ALL = 3'h7;
   localparam logic [2:0] PRIO_NONE = 3'h0;

   typedef struct packed
   {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } ipcr_bus_t;

   typedef struct packed
   {
      logic valid;
      logic [3:0] vector;
      logic [2:0] prio;
   } ipcr_req_t;

   // CPU pipeline events that shape entry timing
   typedef struct packed
   {
      logic instr_last;
      logic two_cycle;
      logic stall;
      logic psv_access;
      logic dword_move;
      logic bit_skip;
      logic enter;
      logic ret;
   } ipcr_cpu_t;
endpackage // ipcr_pkg

// [rtl/ipcr_sync.sv]
module ipcr_sync
#(
   parameter int W = 5
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // Two stages; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         meta_reg <= '0;
         q_reg <= '0;
      end
      else
      begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule // ipcr_sync

// [rtl/ipcr_arbiter.sv]
module ipcr_arbiter
#(
   parameter int N = 16
)
(
   input wire logic [N-1:0] pending,
   input wire logic [N*3-1:0] prio,
   input wire logic [3:0] cpu_level,
   output logic found,
   output logic [3:0] vector,
   output logic [2:0] level
);
   logic [N:0] f_c;
   logic [N*4+3:0] v_c;
   logic [N*3+2:0] l_c;

   assign f_c[N] = 1'b0;
   assign v_c[N*4+3 -: 4] = 4'h0;
   assign l_c[N*3+2 -: 3] = 3'h0;

   // Chain from high vector down: lower index wins a tie
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_chain
         wire logic [2:0] p = prio[i*3 +: 3];
         wire logic elig = pending[i] && ({1'b0, p} > cpu_level);
         wire logic take = elig && (!f_c[i+1] || p >= l_c[(i+1)*3 +: 3]);
         assign f_c[i] = f_c[i+1] || elig;
         assign v_c[i*4 +: 4] = take ? 4'(i) : v_c[(i+1)*4 +: 4];
         assign l_c[i*3 +: 3] = take ? p : l_c[(i+1)*3 +: 3];
      end
   endgenerate

   assign found = f_c[0];
   assign vector = v_c[3:0];
   assign level = l_c[2:0];
endmodule // ipcr_arbiter

// [rtl/ipcr_top.sv]
// The plain strobed port and the placing of the registers were chosen for this implementation.
module ipcr_top
#(
   parameter int N_SRC = 16,
   parameter int N_EXT = 5
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [N_SRC-1:0] src_event,
   input wire logic [N_EXT-1:0] ext_pin,
   input wire logic [3:0] trap_event,
   input wire logic timed_irq_block,
   input wire logic [7:0] cpu_flags,
   input wire logic [7:0] cpu_events,
   input wire logic [3:0] ret_level,
   output logic irq_req,
   output logic [3:0] irq_vector,
   output logic [2:0] irq_prio,
   output logic irq_take,
   output logic alt_vector_select,
   output logic [2:0] acc_trap_enables
);
   ////////////////////////////////////////////////////////////////////////
   ipcr_pkg::ipcr_bus_t bus;
   ipcr_pkg::ipcr_cpu_t cpu;
   ipcr_pkg::ipcr_req_t win;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign cpu = cpu_events;

   logic [2:0] cpu_prio_low_bits_reg;
   logic [2:0] cpu_prio_low_bits_next;
   logic cpu_prio_top_bit_reg;
   logic cpu_prio_top_bit_next;
   logic [7:0] status_misc_reg;
   logic [15:0] core_misc_reg;
   logic nest_disable_reg;
   logic [2:0] trap_en_reg;
   logic [3:0] trap_flag_reg;
   logic [3:0] trap_flag_next;
   logic alt_vec_reg;
   logic [N_EXT-1:0] edge_pol_reg;
   logic [N_SRC-1:0] irq_flag_words_reg;
   logic [N_SRC-1:0] irq_flag_words_next;
   logic [N_SRC-1:0] irq_enable_words_reg;
   logic [N_SRC*3-1:0] irq_priority_words_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic [N_EXT-1:0] ext_sync;
   logic [N_EXT-1:0] ext_prev_reg;
   logic timed_sync;
   logic [1:0] hold_reg;
   logic [1:0] hold_next;
   logic pending_reg;
   logic [3:0] pend_vec_reg;
   logic [2:0] pend_prio_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pins come from outside the clock domain
   ipcr_sync #(.W(N_EXT + 1)) u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .d({timed_irq_block, ext_pin}),
      .q({timed_sync, ext_sync})
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      hit = (a == b);
   endfunction

   wire logic wr_status = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_STATUS);
   wire logic wr_core = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_CORE);
   wire logic wr_gca = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_GCTL_A);
   wire logic wr_gcb = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_GCTL_B);
   wire logic wr_flag = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_FLAG0);
   wire logic wr_en = bus.wr && hit(bus.addr, ipcr_pkg::ADDR_ENABLE0);

   // One write strobe per priority field
   logic [N_SRC-1:0] prio_wr;
   genvar g;
   generate
      for (g = 0; g < N_SRC; g++)
      begin : g_prio
         assign prio_wr[g] = bus.wr
            && hit(bus.addr, ipcr_pkg::ADDR_PRIO0 + 4'(g / 4));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Pin idling high must not look like an edge after reset
   // Limitation: edges in the first three cycles are lost
   logic [1:0] arm_reg;
   wire logic armed = (arm_reg == 2'h3);

   always_ff @(posedge clk)
   begin
      if (!rstn)
         arm_reg <= 2'h0;
      else if (!armed)
         arm_reg <= arm_reg + 2'h1;
   end

   // External pin edge detect, polarity per pin
   wire logic [N_EXT-1:0] ext_rise = ext_sync & ~ext_prev_reg;
   wire logic [N_EXT-1:0] ext_fall = ~ext_sync & ext_prev_reg;
   wire logic [N_EXT-1:0] ext_hit = {N_EXT{armed}}
      & ((edge_pol_reg & ext_fall) | (~edge_pol_reg & ext_rise));

   // Ext pin k drives source k; others come from peripherals
   wire logic [N_SRC-1:0] set_vec =
      src_event | {{(N_SRC-N_EXT){1'b0}}, ext_hit};

   // Set wins over a software clear in the same cycle
   assign irq_flag_words_next = wr_flag
      ? (reg_wdata[N_SRC-1:0] | set_vec)
      : (irq_flag_words_reg | set_vec);
   assign trap_flag_next = (wr_gca
      ? reg_wdata[ipcr_pkg::TRAP_FLAG_LSB +: 4] : trap_flag_reg) | trap_event;

   ////////////////////////////////////////////////////////////////////////
   // Arbitration every cycle over enabled pending flags
   wire logic [N_SRC-1:0] eligible = irq_flag_words_reg & irq_enable_words_reg;
   wire logic [3:0] cpu_level = {cpu_prio_top_bit_reg, cpu_prio_low_bits_reg};
   logic arb_found;
   logic [3:0] arb_vec;
   logic [2:0] arb_prio;

   ipcr_arbiter #(.N(N_SRC)) u_arb
   (
      .pending(eligible),
      .prio(irq_priority_words_reg),
      .cpu_level(cpu_level),
      .found(arb_found),
      .vector(arb_vec),
      .level(arb_prio)
   );

   ////////////////////////////////////////////////////////////////////////
   // Entry waits for instruction end; extra cycle for window cases
   wire logic psv_slow = cpu.psv_access && (cpu.dword_move || cpu.bit_skip);
   wire logic stall_slow = cpu.stall
      && (cpu.two_cycle || cpu.psv_access);
   // Two-cycle ends on its last cycle, same as one-cycle
   wire logic boundary = cpu.instr_last && !timed_sync;
   assign hold_next = (hold_reg != 2'h0) ? hold_reg - 2'h1
      : ((psv_slow || stall_slow) && arb_found ? 2'h1 : 2'h0);
   // No second take in the entry cycle
   assign irq_take = pending_reg && boundary
      && (hold_reg == 2'h0)
      && !cpu.enter;

   // Combined request to the core
   assign win = '{valid: arb_found, vector: arb_vec, prio: arb_prio};
   assign irq_req = pending_reg;
   assign irq_vector = pend_vec_reg;
   assign irq_prio = pend_prio_reg;

   ////////////////////////////////////////////////////////////////////////
   // Priority level updates: entry, return, software write
   wire logic low_writable = !nest_disable_reg;
   always_comb
   begin
      cpu_prio_low_bits_next = cpu_prio_low_bits_reg;
      cpu_prio_top_bit_next = cpu_prio_top_bit_reg;
      if (cpu.enter)
      begin
         if (nest_disable_reg)
            cpu_prio_low_bits_next = ipcr_pkg::PRIO_MASK_ALL;
         else
            cpu_prio_low_bits_next = pend_prio_reg;
      end
      else if (cpu.ret)
      begin
         cpu_prio_low_bits_next = ret_level[2:0];
         cpu_prio_top_bit_next = ret_level[3];
      end
      else if (wr_status && low_writable)
         cpu_prio_low_bits_next =
            reg_wdata[ipcr_pkg::PRIO_LOW_LSB +: 3];
      // Software may only clear the top bit
      if (wr_core && !reg_wdata[ipcr_pkg::PRIO_TOP_BIT] && !cpu.ret)
         cpu_prio_top_bit_next = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_next = ipcr_pkg::RESET_WORD;
      case (bus.addr)
         ipcr_pkg::ADDR_STATUS:
            rdata_next = {8'h00, cpu_prio_low_bits_reg, status_misc_reg[4:0]};
         ipcr_pkg::ADDR_CORE:
         begin
            rdata_next = core_misc_reg;
            rdata_next[ipcr_pkg::PRIO_TOP_BIT] = cpu_prio_top_bit_reg;
         end
         ipcr_pkg::ADDR_GCTL_A:
         begin
            rdata_next[ipcr_pkg::NEST_DIS_BIT] = nest_disable_reg;
            rdata_next[ipcr_pkg::TRAP_EN_LSB +: 3] = trap_en_reg;
            rdata_next[ipcr_pkg::TRAP_FLAG_LSB +: 4] = trap_flag_reg;
         end
         ipcr_pkg::ADDR_GCTL_B:
         begin
            rdata_next[ipcr_pkg::ALT_VEC_BIT] = alt_vec_reg;
            rdata_next[ipcr_pkg::TIMED_BLK_BIT] = timed_sync;
            rdata_next[ipcr_pkg::EDGE_POL_LSB +: N_EXT] = edge_pol_reg;
         end
         ipcr_pkg::ADDR_FLAG0:
            rdata_next[N_SRC-1:0] = irq_flag_words_reg;
         ipcr_pkg::ADDR_ENABLE0:
            rdata_next[N_SRC-1:0] = irq_enable_words_reg;
         ipcr_pkg::ADDR_PRIO0:
            rdata_next = prio_word(irq_priority_words_reg, 0);
         ipcr_pkg::ADDR_PRIO1:
            rdata_next = prio_word(irq_priority_words_reg, 1);
         ipcr_pkg::ADDR_PRIO2:
            rdata_next = prio_word(irq_priority_words_reg, 2);
         ipcr_pkg::ADDR_PRIO3:
            rdata_next = prio_word(irq_priority_words_reg, 3);
         default:
            rdata_next = ipcr_pkg::RESET_WORD;
      endcase
      if (!bus.rd)
         rdata_next = ipcr_pkg::RESET_WORD;
   end

   // Four 3-bit fields per word, one per nibble
   function automatic logic [15:0] prio_word(input logic [N_SRC*3-1:0] p,
                                             input int w);
      logic [15:0] r;
      r = 16'h0000;
      for (int k = 0; k < 4; k++)
         if (w * 4 + k < N_SRC)
            r[k*ipcr_pkg::PRIO_FIELD_W +: 3] = p[(w*4+k)*3 +: 3];
      prio_word = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cpu_prio_low_bits_reg <= ipcr_pkg::PRIO_NONE;
         cpu_prio_top_bit_reg <= 1'b0;
         irq_flag_words_reg <= '0;
         trap_flag_reg <= 4'h0;
         hold_reg <= 2'h0;
         pending_reg <= 1'b0;
         pend_vec_reg <= 4'h0;
         pend_prio_reg <= 3'h0;
         rdata_reg <= ipcr_pkg::RESET_WORD;
         ext_prev_reg <= '0;
      end
      else
      begin
         cpu_prio_low_bits_reg <= cpu_prio_low_bits_next;
         cpu_prio_top_bit_reg <= cpu_prio_top_bit_next;
         irq_flag_words_reg <= irq_flag_words_next;
         trap_flag_reg <= trap_flag_next;
         hold_reg <= hold_next;
         pending_reg <= win.valid && !cpu.enter;
         pend_vec_reg <= win.vector;
         pend_prio_reg <= win.prio;
         rdata_reg <= rdata_next;
         ext_prev_reg <= ext_sync;
      end
   end

   // Plain software-owned control words
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         status_misc_reg <= 8'h00;
         core_misc_reg <= ipcr_pkg::RESET_WORD;
         nest_disable_reg <= 1'b0;
         trap_en_reg <= 3'h0;
         alt_vec_reg <= 1'b0;
         edge_pol_reg <= '0;
         irq_enable_words_reg <= '0;
         irq_priority_words_reg <= '0;
      end
      else
      begin
         if (wr_status)
            status_misc_reg <= {3'h0, reg_wdata[4:0]};
         if (wr_core)
            core_misc_reg <= reg_wdata & 16'hFFF7;
         if (wr_gca)
         begin
            nest_disable_reg <= reg_wdata[ipcr_pkg::NEST_DIS_BIT];
            trap_en_reg <= reg_wdata[ipcr_pkg::TRAP_EN_LSB +: 3];
         end
         if (wr_gcb)
         begin
            alt_vec_reg <= reg_wdata[ipcr_pkg::ALT_VEC_BIT];
            edge_pol_reg <= reg_wdata[ipcr_pkg::EDGE_POL_LSB +: N_EXT];
         end
         if (wr_en)
            irq_enable_words_reg <= reg_wdata[N_SRC-1:0];
         for (int s = 0; s < N_SRC; s++)
            if (prio_wr[s])
               irq_priority_words_reg[s*3 +: 3] <=
                  reg_wdata[(s%4)*ipcr_pkg::PRIO_FIELD_W +: 3];
      end
   end

   assign reg_rdata = rdata_reg;
   assign alt_vector_select = alt_vec_reg;
   assign acc_trap_enables = trap_en_reg;
   // Low status byte from core flags is not mirrored; limitation
   wire logic unused_flags = ^cpu_flags;
endmodule // ipcr_top

// [verif/ipcr_chk.sv]
module ipcr_chk
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic timed_irq_block,
   input wire logic [7:0] cpu_events,
   input wire logic irq_req,
   input wire logic [2:0] irq_prio,
   input wire logic irq_take,
   input wire logic alt_vector_select,
   input wire logic [2:0] acc_trap_enables
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   // Pin is async: four samples cover the two-stage synchroniser
   sequence s_blocked;
      timed_irq_block [*4];
   endsequence
   sequence s_wr_b;
      reg_wr && reg_addr == ipcr_pkg::ADDR_GCTL_B;
   endsequence
   sequence s_wr_a;
      reg_wr && reg_addr == ipcr_pkg::ADDR_GCTL_A;
   endsequence
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   property p_req_prio;
      irq_req |-> irq_prio != 3'h0;
   endproperty
   property p_take_req;
      irq_take |-> irq_req;
   endproperty
   property p_take_last;
      irq_take |-> cpu_events[7];
   endproperty
   property p_blocked;
      s_blocked |-> !irq_take;
   endproperty
   property p_enter_drop;
      cpu_events[1] |=> !irq_req;
   endproperty
   property p_alt_wr;
      s_wr_b |=> alt_vector_select == $past(reg_wdata[15]);
   endproperty
   property p_alt_hold;
      !reg_wr |=> $stable(alt_vector_select);
   endproperty
   property p_trap_wr;
      s_wr_a |=> acc_trap_enables == $past(reg_wdata[10:8]);
   endproperty
   ////////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");
   a_req_prio: assert property (p_req_prio)
      else $error("request at priority zero");
   a_take_req: assert property (p_take_req)
      else $error("take without request");
   a_take_last: assert property (p_take_last)
      else $error("take inside instruction");
   a_blocked: assert property (p_blocked)
      else $error("take while blocked");
   a_enter_drop: assert property (p_enter_drop)
      else $error("request kept after entry");
   a_alt_wr: assert property (p_alt_wr)
      else $error("vector select not written");
   a_alt_hold: assert property (p_alt_hold)
      else $error("vector select changed");
   a_trap_wr: assert property (p_trap_wr)
      else $error("trap enables not written");
endmodule // ipcr_chk

bind ipcr_top ipcr_chk u_chk
(
   .clk(clk),
   .rstn(rstn),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .timed_irq_block(timed_irq_block),
   .cpu_events(cpu_events),
   .irq_req(irq_req),
   .irq_prio(irq_prio),
   .irq_take(irq_take),
   .alt_vector_select(alt_vector_select),
   .acc_trap_enables(acc_trap_enables)
);

// [verif/ipcr_cpu_model.sv]
module ipcr_cpu_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic irq_take,
   input wire logic ack_en,
   input wire logic psv_mode,
   output logic [7:0] cpu_events
);
   timeunit 1ns;
   timeprecision 1ps;
   ipcr_pkg::ipcr_cpu_t ev;
   logic enter_reg;
   // One entry pulse per take while ack_en is high, never two in a row
   always_ff @(posedge clk)
   begin
      if (!rstn)
         enter_reg <= 1'b0;
      else
         enter_reg <= irq_take && ack_en && !enter_reg;
   end
   always_comb
   begin
      ev = '0;
      ev.instr_last = 1'b1;
      ev.psv_access = psv_mode;
      ev.dword_move = psv_mode;
      ev.enter = enter_reg;
   end
   assign cpu_events = ev;
endmodule // ipcr_cpu_model

// [verif/tb_irq_priority_control_regs.sv]
module tb_irq_priority_control_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, reg_wr, reg_rd, timed_irq_block, ack_en, psv_mode;
   logic [3:0] reg_addr, trap_event, irq_vector;
   logic [15:0] reg_wdata, reg_rdata, src_event, en_w, fl_w;
   logic [4:0] ext_pin;
   logic [7:0] cpu_events;
   logic irq_req, irq_take, alt_vector_select;
   logic [2:0] irq_prio, acc_trap_enables, lvl;
   logic [31:0] seed;
   logic [63:0] prio_all;
   int error_cnt, num_checks, lat0, lat1, n;
   ipcr_top DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .src_event(src_event), .ext_pin(ext_pin),
      .trap_event(trap_event), .timed_irq_block(timed_irq_block),
      .cpu_flags(8'h00), .cpu_events(cpu_events), .ret_level(4'h0),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_prio(irq_prio),
      .irq_take(irq_take), .alt_vector_select(alt_vector_select),
      .acc_trap_enables(acc_trap_enables));
   ipcr_cpu_model u_cpu (.clk(clk), .rstn(rstn), .irq_take(irq_take),
      .ack_en(ack_en), .psv_mode(psv_mode), .cpu_events(cpu_events));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Descending scan with >= so the lowest index wins a tie
   function automatic logic [7:0] exp_arb(input logic [15:0] f,
      input logic [15:0] e, input logic [63:0] p, input logic [2:0] l);
      logic [7:0] r;
      r = 8'h00;
      for (int s = 15; s >= 0; s--)
         if (f[s] && e[s] && p[4*s+:3] > l && p[4*s+:3] >= r[2:0])
            r = {1'b1, 4'(s), p[4*s+:3]};
      return r;
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_val(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic chk_reg(input string nm, input logic [3:0] a,
      input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_val(nm, e & m, reg_rdata & m);
   endtask
   task automatic pulse_src(input logic [15:0] v);
      @(posedge clk);
      src_event <= v;
      @(posedge clk);
      src_event <= 16'h0000;
   endtask
   // Window access only in the cycle before the plain take
   task automatic measure(input int t, output int c);
      c = 0;
      @(posedge clk);
      timed_irq_block <= 1'b1;
      repeat (8) @(posedge clk);
      timed_irq_block <= 1'b0;
      ack_en <= 1'b1;
      while (c < 30 && irq_take !== 1'b1)
      begin
         psv_mode <= (t > 0) && (c + 1 == t);
         @(posedge clk);
         #1;
         c++;
      end
      @(posedge clk);
      ack_en <= 1'b0;
      psv_mode <= 1'b0;
      repeat (3) @(posedge clk);
      wr(ipcr_pkg::ADDR_STATUS, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      #(40 * 40000);
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      {rstn, reg_wr, reg_rd, timed_irq_block, ack_en, psv_mode} = '0;
      {reg_addr, trap_event, reg_wdata, src_event, ext_pin} = '0;
      error_cnt = 0;
      num_checks = 0;
      seed = 32'h0B87;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      chk_reg("status", ipcr_pkg::ADDR_STATUS, 16'h00E0, 0);
      chk_reg("core", ipcr_pkg::ADDR_CORE, 16'h0008, 0);
      chk_reg("ctl_a", ipcr_pkg::ADDR_GCTL_A, 16'h871E, 0);
      chk_reg("ctl_b", ipcr_pkg::ADDR_GCTL_B, 16'hC01F, 0);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'hFFFF, 0);
      chk_reg("unmapped", 4'hA, 16'hFFFF, 0);
      wr(ipcr_pkg::ADDR_STATUS, 16'h00A0);
      chk_reg("status", ipcr_pkg::ADDR_STATUS, 16'h00E0, 16'h00A0);
      wr(ipcr_pkg::ADDR_CORE, 16'h0008);
      chk_reg("core", ipcr_pkg::ADDR_CORE, 16'h0008, 0);
      wr(ipcr_pkg::ADDR_GCTL_A, 16'h8700);
      #1;
      chk_val("trap_en", 16'h0007, {13'h0, acc_trap_enables});
      wr(ipcr_pkg::ADDR_STATUS, 16'h00E0);
      chk_reg("status", ipcr_pkg::ADDR_STATUS, 16'h00E0, 16'h00A0);
      pulse_src(16'h0000);
      trap_event <= 4'hF;
      @(posedge clk);
      trap_event <= 4'h0;
      chk_reg("ctl_a", ipcr_pkg::ADDR_GCTL_A, 16'h871E, 16'h871E);
      wr(ipcr_pkg::ADDR_GCTL_A, 16'h0000);
      wr(ipcr_pkg::ADDR_GCTL_B, 16'h8015);
      #1;
      chk_val("alt", 16'h0001, {15'h0, alt_vector_select});
      chk_reg("ctl_b", ipcr_pkg::ADDR_GCTL_B, 16'hC01F, 16'h8015);
      ext_pin <= 5'h1F;
      repeat (4) @(posedge clk);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'hFFFF, 16'h000A);
      ext_pin <= 5'h00;
      repeat (4) @(posedge clk);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'hFFFF, 16'h001F);
      wr(ipcr_pkg::ADDR_GCTL_B, 16'h0000);
      repeat (4) @(posedge clk);
      wr(ipcr_pkg::ADDR_FLAG0, 16'h0000);
      pulse_src(16'h8001);
      repeat (5) @(posedge clk);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'hFFFF, 16'h8001);
      wr(ipcr_pkg::ADDR_FLAG0, 16'h0000);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'hFFFF, 0);
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         en_w = (i == 0) ? 16'hFFFF : seed[15:0];
         fl_w = (i == 0) ? 16'hFFFF : seed[31:16];
         seed = lfsr(seed);
         prio_all = (i == 0) ? {16{4'h5}} : {seed, lfsr(seed)};
         prio_all = prio_all & {16{4'h7}};
         lvl = (i == 1) ? 3'h7 : seed[7:5];
         for (int k = 0; k < 4; k++)
            wr(4'(ipcr_pkg::ADDR_PRIO0 + k), prio_all[16*k+:16]);
         wr(ipcr_pkg::ADDR_ENABLE0, en_w);
         wr(ipcr_pkg::ADDR_STATUS, {8'h00, lvl, 5'h00});
         pulse_src(fl_w);
         repeat (3) @(posedge clk);
         #1;
         chk_val("irq", {8'h00, exp_arb(fl_w, en_w, prio_all, lvl)},
            irq_req ? {8'h00, irq_req, irq_vector, irq_prio} : 0);
         wr(ipcr_pkg::ADDR_FLAG0, 16'h0000);
      end
      wr(ipcr_pkg::ADDR_ENABLE0, 16'h0004);
      wr(ipcr_pkg::ADDR_PRIO0, 16'h0300);
      wr(ipcr_pkg::ADDR_STATUS, 16'h0000);
      pulse_src(16'h0004);
      measure(0, lat0);
      chk_reg("flags", ipcr_pkg::ADDR_FLAG0, 16'h0004, 16'h0004);
      measure(lat0, lat1);
      chk_val("latency", 16'h0001, 16'(lat1 == lat0 + 1));
      wr(ipcr_pkg::ADDR_GCTL_A, 16'h8000);
      measure(0, n);
      chk_val("latency_nest", 16'(lat0), 16'(n));
      chk_reg("status", ipcr_pkg::ADDR_STATUS, 16'h00E0, 16'h00E0);
      wrap_up();
   end
endmodule // tb_irq_priority_control_regs
